/* File: verilog/adsc_pkg.sv */
package adsc_pkg;

   // divider select codes and their ratios
   localparam logic [2:0] DIV_SEL_1   = 3'h4;
   localparam logic [2:0] DIV_SEL_2   = 3'h0;
   localparam logic [2:0] DIV_SEL_4   = 3'h5;
   localparam logic [2:0] DIV_SEL_8   = 3'h1;
   localparam logic [2:0] DIV_SEL_16  = 3'h6;
   localparam logic [2:0] DIV_SEL_32  = 3'h2;
   localparam logic [5:0] RATIO_1     = 6'h01;
   localparam logic [5:0] RATIO_2     = 6'h02;
   localparam logic [5:0] RATIO_4     = 6'h04;
   localparam logic [5:0] RATIO_8     = 6'h08;
   localparam logic [5:0] RATIO_16    = 6'h10;
   localparam logic [5:0] RATIO_32    = 6'h20;

   // conversion length in conversion clock periods per resolution
   localparam int         RES_8       = 8;
   localparam int         RES_9       = 9;
   localparam int         RES_12      = 12;
   localparam logic [6:0] LEN_RES_8   = 7'h40;
   localparam logic [6:0] LEN_RES_9   = 7'h4C;
   localparam logic [6:0] LEN_RES_12  = 7'h50;

   // timing: least conversion clock period, system clock period
   localparam int         CONV_CLK_MIN_NS = 1000;
   localparam int         SYS_CLK_PER_NS  = 8;
   localparam int         CONV_CLK_MIN_CYC_I = (CONV_CLK_MIN_NS + SYS_CLK_PER_NS - 1) / SYS_CLK_PER_NS;
   localparam logic [7:0] CONV_CLK_MIN_CYC   = 8'(CONV_CLK_MIN_CYC_I);

   // analog pin configuration
   localparam logic [2:0] PCFG_ALL_DIGITAL = 3'h0;
   localparam logic [2:0] PCFG_ONE         = 3'h1;
   localparam logic [2:0] PCFG_TWO         = 3'h2;
   localparam logic [2:0] PCFG_THREE       = 3'h3;
   localparam logic [3:0] AMASK_NONE       = 4'h0;
   localparam logic [3:0] AMASK_ONE        = 4'h1;
   localparam logic [3:0] AMASK_TWO        = 4'h3;
   localparam logic [3:0] AMASK_THREE      = 4'h7;
   localparam logic [3:0] AMASK_ALL        = 4'hF;
   localparam int         RESULT_W         = 16;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HOLD = 4'h2,
      ST_SYNC = 4'h4,
      ST_CONV = 4'h8
   } adsc_state_t;

   typedef struct packed {
      adsc_state_t state;
      logic        start;
      logic [4:0]  div_cnt;
      logic        tick;
      logic [6:0]  conv_cnt;
      logic        pending;
      logic        irq_flag;
      logic        irq;
      logic        core_reset;
      logic        core_sample;
      logic        power_down;
      logic        too_fast;
      logic [3:0]  analog_en;
      logic [3:0]  pin_input;
      logic [3:0]  pullup_en;
      logic [1:0]  channel;
      logic [7:0]  res_high;
      logic [7:0]  res_low;
   } adsc_regs_t;

endpackage : adsc_pkg

/* File: verilog/adsc_control.sv */
// Contract
// - conversion clock is the system clock divided by the selected ratio.
// - select 100=/1, 000=/2, 101=/4, 001=/8, 110=/16, 010=/32.
// - start bit going 0-1-0 begins a conversion.
// - start held high keeps converter reset and pending flag at one.
// - pending flag falls when conversion ends; result registers then valid.
// - conversion lasts 64, 76 or 80 periods for 8, 9, 12 bits.
// - conversion runs alone in hardware, never stalling the processor.
// - analog-enabled pins are inputs whatever the direction register says.
// - pull-ups only on digital pins; analog pins lose them.
// - a re-init pulse leaves the pending flag high.
// - pin config all zero gives digital pins and converter powered down.
// - changing selection to all zero needs no re-init pulse.
// - interrupt reaches processor only with global and converter enables set.
// - pin config 100 or above makes all four pins analog.
// - end of conversion sets the request flag regardless of enables.
// - wide results: upper eight bits high, remaining bits left-justified low.
module adsc_control
   import adsc_pkg::*;
#(
   parameter int RES_BITS = RES_12
) (
   input  wire logic                clock_in,
   input  wire logic                sys_rst_in,
   input  wire logic [2:0]          conv_clock_divider_sel_in,
   input  wire logic [2:0]          analog_pin_config_in,
   input  wire logic [2:0]          analog_channel_sel_in,
   input  wire logic                start_in,
   input  wire logic [3:0]          port_dir_input_in,
   input  wire logic [3:0]          port_pullup_reg_in,
   input  wire logic                global_irq_enable_in,
   input  wire logic                converter_irq_enable_in,
   input  wire logic                irq_flag_clear_in,
   input  wire logic [RES_BITS-1:0] core_result_in,
   output logic                     conversion_pending_flag_out,
   output logic                     irq_request_flag_out,
   output logic                     irq_out,
   output logic                     conv_clock_tick_out,
   output logic                     conv_clock_too_fast_out,
   output logic                     core_reset_out,
   output logic                     core_sample_out,
   output logic                     core_power_down_out,
   output logic [1:0]               core_channel_out,
   output logic [3:0]               pin_analog_en_out,
   output logic [3:0]               pin_input_out,
   output logic [3:0]               pin_pullup_en_out,
   output logic [7:0]               result_high_reg_out,
   output logic [7:0]               result_low_reg_out
);

   localparam logic [6:0] CONV_LEN = (RES_BITS == RES_8) ? LEN_RES_8 :
                                     (RES_BITS == RES_9) ? LEN_RES_9 : LEN_RES_12;
   localparam int         JUSTIFY  = RESULT_W - RES_BITS;

   adsc_regs_t r_q;
   adsc_regs_t r_d;
   logic [5:0]          ratio;
   logic [3:0]          amask;
   logic [RESULT_W-1:0] res_wide;

   always_comb begin
      unique case (conv_clock_divider_sel_in)
         DIV_SEL_1:  ratio = RATIO_1;
         DIV_SEL_2:  ratio = RATIO_2;
         DIV_SEL_4:  ratio = RATIO_4;
         DIV_SEL_8:  ratio = RATIO_8;
         DIV_SEL_16: ratio = RATIO_16;
         DIV_SEL_32: ratio = RATIO_32;
         // the two unlisted codes fall back to the slowest, safest clock
         default:    ratio = RATIO_32;
      endcase
      unique case (analog_pin_config_in)
         PCFG_ALL_DIGITAL: amask = AMASK_NONE;
         PCFG_ONE:         amask = AMASK_ONE;
         PCFG_TWO:         amask = AMASK_TWO;
         PCFG_THREE:       amask = AMASK_THREE;
         default:          amask = AMASK_ALL;
      endcase
      res_wide = RESULT_W'(core_result_in) << JUSTIFY;
   end

   always_comb begin
      r_d = r_q;
      r_d.start       = start_in;
      r_d.core_sample = 1'b0;
      // divider free-runs so the tick grid is stable for the sequencer
      if (r_q.div_cnt >= 5'(ratio - RATIO_1)) begin
         r_d.div_cnt = '0;
         r_d.tick    = 1'b1;
      end else begin
         r_d.div_cnt = r_q.div_cnt + 5'h01;
         r_d.tick    = 1'b0;
      end
      // period counted in system cycles, so no product can overflow the compare
      r_d.too_fast   = ({2'h0, ratio} < CONV_CLK_MIN_CYC);
      // pin function override is registered from software bits, one cycle behind them
      r_d.analog_en  = amask;
      r_d.pin_input  = port_dir_input_in | amask;
      r_d.pullup_en  = port_pullup_reg_in & ~amask;
      r_d.power_down = (amask == AMASK_NONE);
      r_d.channel    = analog_channel_sel_in[1:0];

      // sequencer runs beside the processor; no stall path exists
      unique case (r_q.state)
         ST_IDLE: begin
            r_d.core_reset = 1'b0;
         end
         ST_HOLD: begin
            r_d.core_reset = 1'b1;
            r_d.pending    = 1'b1;
            if (!start_in) begin
               r_d.state = ST_SYNC;
            end
         end
         ST_SYNC: begin
            r_d.core_reset = 1'b0;
            if (r_q.tick) begin
               r_d.state    = ST_CONV;
               r_d.conv_cnt = '0;
            end
         end
         ST_CONV: begin
            if (r_q.tick) begin
               if (r_q.conv_cnt == 7'(CONV_LEN - 7'h01)) begin
                  r_d.state       = ST_IDLE;
                  r_d.pending     = 1'b0;
                  r_d.core_sample = 1'b1;
                  r_d.res_high    = res_wide[15:8];
                  r_d.res_low     = res_wide[7:0];
               end else begin
                  r_d.conv_cnt = r_q.conv_cnt + 7'h01;
               end
            end
         end
         default: begin
            r_d.state = ST_IDLE;
         end
      endcase
      // a new rising edge aborts anything in flight and resets the core
      if (start_in && !r_q.start) begin
         r_d.state       = ST_HOLD;
         r_d.pending     = 1'b1;
         r_d.core_reset  = 1'b1;
         // a completion tick in this same cycle is dropped with the aborted run
         r_d.core_sample = 1'b0;
         r_d.res_high    = r_q.res_high;
         r_d.res_low     = r_q.res_low;
      end

      // set beats clear in the same cycle
      if (r_d.core_sample) begin
         r_d.irq_flag = 1'b1;
      end else if (irq_flag_clear_in) begin
         r_d.irq_flag = 1'b0;
      end
      r_d.irq = r_d.irq_flag & global_irq_enable_in & converter_irq_enable_in;
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         r_q            <= '0;
         r_q.state      <= ST_IDLE;
         r_q.power_down <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign conversion_pending_flag_out = r_q.pending;
   assign irq_request_flag_out        = r_q.irq_flag;
   assign irq_out                     = r_q.irq;
   assign conv_clock_tick_out         = r_q.tick;
   assign conv_clock_too_fast_out     = r_q.too_fast;
   assign core_reset_out              = r_q.core_reset;
   assign core_sample_out             = r_q.core_sample;
   assign core_power_down_out         = r_q.power_down;
   assign core_channel_out            = r_q.channel;
   assign pin_analog_en_out           = r_q.analog_en;
   assign pin_input_out               = r_q.pin_input;
   assign pin_pullup_en_out           = r_q.pullup_en;
   assign result_high_reg_out         = r_q.res_high;
   assign result_low_reg_out          = r_q.res_low;

endmodule : adsc_control

/* File: verification/adsc_core_model.sv */
module adsc_core_model (
   input  wire logic        clock_in,
   input  wire logic        core_reset_in,
   input  wire logic [11:0] value_in,
   output logic      [11:0] result_out = 12'h000
);
   timeunit 1ns;
   timeprecision 1ps;
   // toggles while held in reset, so a sample taken too early never looks valid
   always_ff @(posedge clock_in) result_out <= core_reset_in ? ~result_out : value_in;
endmodule : adsc_core_model

/* File: verification/adsc_checker.sv */
module adsc_checker (
   input wire logic       clock_in,
   input wire logic       sys_rst_in,
   input wire logic       start_in,
   input wire logic [2:0] analog_pin_config_in,
   input wire logic [3:0] port_dir_input_in,
   input wire logic [3:0] port_pullup_reg_in,
   input wire logic       global_irq_enable_in,
   input wire logic       converter_irq_enable_in,
   input wire logic       conversion_pending_flag_out,
   input wire logic       irq_request_flag_out,
   input wire logic       irq_out,
   input wire logic       core_reset_out,
   input wire logic       core_sample_out,
   input wire logic       core_power_down_out,
   input wire logic [3:0] pin_analog_en_out,
   input wire logic [3:0] pin_input_out,
   input wire logic [3:0] pin_pullup_en_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // past values from inside reset are not trusted
   logic up_q;
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         up_q <= 1'b0;
      end else begin
         up_q <= 1'b1;
      end
   end
   chk_hold_on_rise: assert property ($rose(start_in) |=> conversion_pending_flag_out && core_reset_out)
      else $error("start rise did not hold the converter");
   chk_hold_stays: assert property (start_in && $past(start_in) && $past(conversion_pending_flag_out)
      |-> conversion_pending_flag_out && !core_sample_out) else $error("pending dropped while start high");
   chk_done_flags: assert property ($fell(conversion_pending_flag_out)
      |-> core_sample_out && irq_request_flag_out) else $error("completion without sample and request flag");
   chk_sample_once: assert property (core_sample_out |=> !core_sample_out) else $error("sample pulse too long");
   chk_sample_done: assert property (core_sample_out |-> !conversion_pending_flag_out && !core_reset_out)
      else $error("sample while conversion still pending");
   chk_irq_gate: assert property (up_q |-> irq_out == (irq_request_flag_out
      && $past(global_irq_enable_in) && $past(converter_irq_enable_in))) else $error("interrupt gating wrong");
   chk_pin_input: assert property (up_q |-> pin_input_out == ($past(port_dir_input_in) | pin_analog_en_out))
      else $error("analog pin not forced to input");
   chk_pullup_cut: assert property (up_q
      |-> pin_pullup_en_out == ($past(port_pullup_reg_in) & ~pin_analog_en_out))
      else $error("pull-up left on analog pin");
   chk_all_analog: assert property (up_q && $past(analog_pin_config_in[2]) |-> pin_analog_en_out == 4'hF)
      else $error("high pin config not all analog");
   chk_power_down: assert property (up_q |-> core_power_down_out == ($past(analog_pin_config_in) == 3'h0))
      else $error("power down state wrong");
endmodule : adsc_checker
bind adsc_control adsc_checker chk_i (.*);

/* File: verification/tb.sv */
module tb
   import adsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in = 1'b0, sys_rst_in = 1'b1, start_in = 1'b0, gie = 1'b0, cie = 1'b0, clr = 1'b0;
   logic [2:0]  div_sel = DIV_SEL_1, pcfg = 3'h0, chan = 3'h0;
   logic [3:0]  dir = 4'h0, pull = 4'h0, aen, pin_in, pu;
   logic [11:0] val = 12'h000, core_res;
   logic [7:0]  rh, rl;
   logic [1:0]  ch_o;
   logic        pend, iflag, irq, crst, samp, pdn, tick, fast;
   logic [11:0] exp_q [$];
   logic [2:0]  codes [6] = '{DIV_SEL_1, DIV_SEL_2, DIV_SEL_4, DIV_SEL_8, DIV_SEL_16, DIV_SEL_32};
   integer      seed = 32'hba3a;
   int          fail_count = 0, compares = 0, n, t;
   always #4 clock_in = ~clock_in;
   adsc_control #(.RES_BITS(RES_12)) dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .conv_clock_divider_sel_in(div_sel), .analog_pin_config_in(pcfg), .analog_channel_sel_in(chan),
      .start_in(start_in), .port_dir_input_in(dir), .port_pullup_reg_in(pull), .global_irq_enable_in(gie),
      .converter_irq_enable_in(cie), .irq_flag_clear_in(clr), .core_result_in(core_res),
      .conversion_pending_flag_out(pend), .irq_request_flag_out(iflag), .irq_out(irq),
      .conv_clock_tick_out(tick), .conv_clock_too_fast_out(fast), .core_reset_out(crst), .core_sample_out(samp),
      .core_power_down_out(pdn), .core_channel_out(ch_o), .pin_analog_en_out(aen), .pin_input_out(pin_in),
      .pin_pullup_en_out(pu), .result_high_reg_out(rh), .result_low_reg_out(rl));
   adsc_core_model core (.clock_in(clock_in), .core_reset_in(crst), .value_in(val), .result_out(core_res));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   function automatic logic [3:0] amask(input int c);
      return c >= 4 ? 4'hF : 4'((1 << c) - 1);
   endfunction : amask
   // start pulse from a low start bit, then time the run against its bounds
   task automatic convert(input int lo, input int hi);
      @(posedge clock_in) begin
         start_in <= 1'b1;
         clr <= 1'b0;
      end
      @(posedge clock_in) start_in <= 1'b0;
      exp_q.push_back(val);
      @(posedge clock_in) check(16'({pend, crst, iflag}), 16'h6);
      t = 0;
      for (n = 0; pend === 1'b1 && n < 4000; n++) begin
         @(posedge clock_in);
         t += int'(tick);
      end
      if (n >= 4000) begin
         fail_count++;
         final_report();
      end
      check(16'(n >= lo && n <= hi), 16'h1);
      check(16'(t >= 81 && t <= 82), 16'h1);
      check(16'({samp, iflag, irq}), 16'({2'b11, gie & cie}));
      check({rh, rl}, {exp_q.pop_front(), 4'h0});
   endtask : convert
   initial begin
      repeat (5) @(posedge clock_in);
      check(16'({pend, pdn}), 16'h1);
      sys_rst_in <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(posedge clock_in) begin
            div_sel <= codes[i];
            pcfg <= 3'(i);
            chan <= 3'(i & 3);
            {gie, cie} <= 2'(i);
            clr <= 1'b1;
            dir <= 4'($random(seed));
            pull <= 4'($random(seed));
            val <= 12'($random(seed));
         end
         convert((80 << i) + 2, (81 << i) + 1);
         check(16'(fast), 16'((SYS_CLK_PER_NS << i) < CONV_CLK_MIN_NS));
         check(16'({aen, pin_in, pu}), 16'({amask(i), dir | amask(i), pull & ~amask(i)}));
         check(16'({pdn, ch_o}), 16'({i == 0, 2'(i & 3)}));
         $display("divider test %0d done", i);
      end
      @(posedge clock_in) begin
         div_sel <= DIV_SEL_1;
         start_in <= 1'b1;
         clr <= 1'b1;
      end
      repeat (20) @(posedge clock_in);
      check(16'({pend, crst, samp}), 16'h6);
      start_in <= 1'b0;
      repeat (30) @(posedge clock_in);
      // a second pulse mid-run must throw away the running conversion
      convert(82, 82);
      $display("hold and abort test done");
      // reset in the middle of a conversion, then a clean run afterwards
      @(posedge clock_in) start_in <= 1'b1;
      @(posedge clock_in) start_in <= 1'b0;
      repeat (20) @(posedge clock_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      check(16'({pend, crst, samp, iflag, pdn, rh}), 16'h0100);
      sys_rst_in <= 1'b0;
      convert(82, 82);
      $display("mid-run reset test done");
      final_report();
   end
endmodule : tb
